//--- design/gci_pkg.sv
// Package of constants for the pin command interpreter
package gci_pkg;
	// ---------------------------------------------------------------
	// Frame shape
	// ---------------------------------------------------------------
	localparam int GCI_CMD_BYTES = 9;
	localparam int GCI_RSP_BYTES = 5;
	localparam int GCI_PARAM_BYTES = 4;
	// ---------------------------------------------------------------
	// Command codes and answers
	// ---------------------------------------------------------------
	localparam logic [7:0] GCI_GET_FUNC = 8'h10;
	localparam logic [7:0] GCI_GET_DIR = 8'h11;
	localparam logic [7:0] GCI_GET_LEVEL = 8'h12;
	localparam logic [7:0] GCI_GET_STATE = 8'h13;
	localparam logic [7:0] GCI_SET_DIR = 8'h19;
	localparam logic [7:0] GCI_SET_LEVEL = 8'h1A;
	localparam logic [7:0] GCI_SET_STATE = 8'h1B;
	localparam logic [7:0] GCI_BAD_CMD = 8'hFF;
	// ---------------------------------------------------------------
	// Defaults
	// ---------------------------------------------------------------
	localparam int GCI_NPINS = 3;
	localparam logic [31:0] GCI_UNDEF_BITS = 32'h0000_0000;
	// Command kinds seen by the byte link's sequencer
	typedef enum {GCI_K_READ, GCI_K_WRITE, GCI_K_BAD} gci_kind_e;
endpackage : gci_pkg

//--- design/gci_req_if.sv
// Interface carrying one decoded command and its reply word
`timescale 1ns/1ps
interface gci_req_if;
	logic req;
	logic [7:0] cmd;
	logic [31:0] mask;
	logic [31:0] value;
	logic done;
	logic [31:0] result;
	modport asm_side (output req, output cmd, output mask, output value,
		input done, input result);
	modport exe_side (input req, input cmd, input mask, input value,
		output done, output result);
endinterface : gci_req_if

//--- design/gci_pin_bank.sv
// Pin state bank: direction, level and state per pin, with pad logic
`timescale 1ns/1ps
module gci_pin_bank
	import gci_pkg::*;
#(
	parameter int NPINS = GCI_NPINS
) (
	input wire logic clk,
	input wire logic nrst,
	gci_req_if.exe_side rq,
	input wire logic boot_load,
	input wire logic [NPINS-1:0] boot_func,
	input wire logic [NPINS-1:0] boot_dir,
	input wire logic [NPINS-1:0] boot_level,
	input wire logic [NPINS-1:0] pin_in,
	output logic [NPINS-1:0] pin_out,
	output logic [NPINS-1:0] pin_oe
);
	// ---------------------------------------------------------------
	// Volatile pin state
	// ---------------------------------------------------------------
	// Parameters are four bytes wide, so no more than 32 pins fit
	if (NPINS < 1 || NPINS > 32) begin : g_bad_npins
		$error("NPINS must be 1..32");
	end
	logic [NPINS-1:0] func_r;
	logic [NPINS-1:0] dir_r;
	logic [NPINS-1:0] level_r;
	logic [NPINS-1:0] state_r;
	logic [NPINS-1:0] wmask;
	logic [NPINS-1:0] wval;
	logic [NPINS-1:0] in_state;
	logic [NPINS-1:0] cur_state;
	logic [31:0] rd_word;
	// Only pins in general purpose use may be written
	assign wmask = rq.mask[NPINS-1:0] & func_r;
	assign wval = rq.value[NPINS-1:0];
	// Inputs translate through the active level
	assign in_state = pin_in ^ level_r;
	assign cur_state = (dir_r & state_r) | (~dir_r & in_state);
	// Function map comes from reset (all general purpose) or the boot configuration, never a command
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			func_r <= '1;
		end else if (boot_load) begin
			func_r <= boot_func;
		end
	end
	// Directions: reset to inputs, boot reload, masked write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dir_r <= '0;
		end else if (boot_load) begin
			dir_r <= boot_dir;
		end else if (rq.req && rq.cmd == GCI_SET_DIR) begin
			dir_r <= (dir_r & ~wmask) | (wval & wmask);
		end
	end
	// Active levels: reset to active low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			level_r <= '1;
		end else if (boot_load) begin
			level_r <= boot_level;
		end else if (rq.req && rq.cmd == GCI_SET_LEVEL) begin
			level_r <= (level_r & ~wmask) | (wval & wmask);
		end
	end
	// Output states: inactive after reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= '0;
		end else if (boot_load) begin
			state_r <= '0;
		end else if (rq.req && rq.cmd == GCI_SET_STATE) begin
			state_r <= (state_r & ~wmask) | (wval & wmask);
		end
	end
	// Read word: values are those after any write, bits of dedicated pins
	// read as a fixed filler since their value is undefined
	always_comb begin
		rd_word = GCI_UNDEF_BITS;
		unique case (rq.cmd)
			GCI_GET_FUNC: rd_word[NPINS-1:0] = func_r;
			GCI_GET_DIR, GCI_SET_DIR: rd_word[NPINS-1:0] = dir_r;
			GCI_GET_LEVEL, GCI_SET_LEVEL: rd_word[NPINS-1:0] = level_r;
			GCI_GET_STATE, GCI_SET_STATE: rd_word[NPINS-1:0] = cur_state;
			default: rd_word = GCI_UNDEF_BITS;
		endcase
		if (rq.cmd != GCI_GET_FUNC) begin
			rd_word[NPINS-1:0] = rd_word[NPINS-1:0] & func_r;
		end
	end
	// Answer one cycle after the request so writes are already visible
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rq.done <= 1'b0;
		end else begin
			rq.done <= rq.req;
		end
	end
	assign rq.result = rd_word;
	// Pad drive: only general purpose outputs are driven
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_out <= '0;
			pin_oe <= '0;
		end else begin
			pin_out <= state_r ^ level_r;
			pin_oe <= dir_r & func_r;
		end
	end
endmodule : gci_pin_bank

//--- design/gci_link_shift.sv
// Byte shifter: assembles nine-byte commands, serialises replies
`timescale 1ns/1ps
module gci_link_shift
	import gci_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic enable,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	gci_req_if.asm_side rq
);
	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	typedef enum {GCI_S_RX, GCI_S_EXEC, GCI_S_WAIT, GCI_S_TX} gci_state_e;
	gci_state_e st_r;
	logic [3:0] cnt_r;
	logic [7:0] cmd_r;
	logic [31:0] p1_r;
	logic [31:0] p2_r;
	logic [31:0] rsp_r;
	logic [2:0] rsp_len_r;
	localparam logic [3:0] LAST_RX = 4'(GCI_CMD_BYTES - 1);
	localparam logic [2:0] RSP_FULL = 3'(GCI_RSP_BYTES);

	// Classify the command byte
	function automatic gci_kind_e kind_of(input logic [7:0] c);
		unique case (c)
			GCI_GET_FUNC, GCI_GET_DIR, GCI_GET_LEVEL,
				GCI_GET_STATE: kind_of = GCI_K_READ;
			GCI_SET_DIR, GCI_SET_LEVEL,
				GCI_SET_STATE: kind_of = GCI_K_WRITE;
			default: kind_of = GCI_K_BAD;
		endcase
	endfunction : kind_of

	// Byte intake; one command in flight keeps replies in order
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= GCI_S_RX;
			cnt_r <= '0;
			cmd_r <= '0;
			p1_r <= '0;
			p2_r <= '0;
			rsp_r <= '0;
			rsp_len_r <= '0;
		end else begin
			unique case (st_r)
				GCI_S_RX: begin
					if (!enable) begin
						cnt_r <= '0;
					end else if (rx_valid) begin
						// Little-endian: first byte holds pins 0..7
						if (cnt_r == 4'd0) begin
							cmd_r <= rx_data;
						end else if (cnt_r <= 4'd4) begin
							p1_r <= {rx_data, p1_r[31:8]};
						end else begin
							p2_r <= {rx_data, p2_r[31:8]};
						end
						if (cnt_r == LAST_RX) begin
							cnt_r <= '0;
							st_r <= GCI_S_EXEC;
						end else begin
							cnt_r <= cnt_r + 4'd1;
						end
					end
				end
				GCI_S_EXEC: begin
					if (kind_of(cmd_r) == GCI_K_BAD) begin
						rsp_len_r <= 3'd1;
						st_r <= GCI_S_TX;
					end else begin
						st_r <= GCI_S_WAIT;
					end
				end
				GCI_S_WAIT: begin
					if (rq.done) begin
						rsp_r <= rq.result;
						rsp_len_r <= RSP_FULL;
						st_r <= GCI_S_TX;
					end
				end
				GCI_S_TX: begin
					if (tx_ready) begin
						if (cnt_r == 4'(rsp_len_r - 3'd1)) begin
							cnt_r <= '0;
							st_r <= GCI_S_RX;
						end else begin
							cnt_r <= cnt_r + 4'd1;
						end
						if (cnt_r != 4'd0) begin
							rsp_r <= {8'h00, rsp_r[31:8]};
						end
					end
				end
			endcase
		end
	end
	// Reply byte: echoed command then parameter bytes low first, or GCI_BAD_CMD alone for a bad code
	assign tx_valid = (st_r == GCI_S_TX);
	assign tx_data = (rsp_len_r == 3'd1) ? GCI_BAD_CMD :
		(cnt_r == 4'd0) ? cmd_r : rsp_r[7:0];
	assign tx_last = (st_r == GCI_S_TX) && (cnt_r == 4'(rsp_len_r - 3'd1));
	assign rx_ready = (st_r == GCI_S_RX) && enable;
	// Request pulses once; parameter 2 is unused by reads
	assign rq.req = (st_r == GCI_S_EXEC) && (kind_of(cmd_r) != GCI_K_BAD);
	assign rq.cmd = cmd_r;
	assign rq.mask = (kind_of(cmd_r) == GCI_K_WRITE) ? p1_r : '0;
	assign rq.value = (kind_of(cmd_r) == GCI_K_WRITE) ? p2_r : '0;
endmodule : gci_link_shift

//--- design/gci_top.sv
// Top of the pin command interpreter: byte link and pin bank
`timescale 1ns/1ps
module gci_top
	import gci_pkg::*;
#(
	parameter int NPINS = GCI_NPINS
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ctl_enable,
	input wire logic boot_load,
	input wire logic [NPINS-1:0] boot_func,
	input wire logic [NPINS-1:0] boot_dir,
	input wire logic [NPINS-1:0] boot_level,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	input wire logic [NPINS-1:0] pin_in,
	output logic [NPINS-1:0] pin_out,
	output logic [NPINS-1:0] pin_oe
);
	// ---------------------------------------------------------------
	// Transport-neutral byte link feeds the pin bank
	// ---------------------------------------------------------------
	gci_req_if rq ();
	// One byte stream for both transports; framing is the caller's job
	gci_link_shift u_link (
		.clk(clk),
		.nrst(nrst),
		.enable(ctl_enable),
		.rx_valid(rx_valid),
		.rx_data(rx_data),
		.rx_ready(rx_ready),
		.tx_valid(tx_valid),
		.tx_data(tx_data),
		.tx_last(tx_last),
		.tx_ready(tx_ready),
		.rq(rq.asm_side)
	);
	gci_pin_bank #(.NPINS(NPINS)) u_bank (
		.clk(clk),
		.nrst(nrst),
		.rq(rq.exe_side),
		.boot_load(boot_load),
		.boot_func(boot_func),
		.boot_dir(boot_dir),
		.boot_level(boot_level),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe(pin_oe)
	);
endmodule : gci_top

//--- bench/gci_top_checker.sv
// Checker for the command interpreter's byte link
`timescale 1ns/1ps
module gci_top_checker
	import gci_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ctl_enable,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic tx_ready
);
	logic [3:0] rx_cnt_r;
	logic [2:0] tx_cnt_r;
	logic [7:0] code_r;
	logic rx_take;
	logic tx_take;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Handshakes on both streams
	assign rx_take = rx_valid && rx_ready;
	assign tx_take = tx_valid && tx_ready;
	// Frame position; a dropped enable discards the partial frame
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) rx_cnt_r <= 4'h0;
		else if (!ctl_enable) rx_cnt_r <= 4'h0;
		else if (rx_take) rx_cnt_r <= (rx_cnt_r == 4'h8) ? 4'h0 : rx_cnt_r + 4'h1;
	end
	// Code byte kept for the echo check
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) code_r <= 8'h00;
		else if (rx_take && rx_cnt_r == 4'h0) code_r <= rx_data;
	end
	// Reply byte position
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) tx_cnt_r <= 3'h0;
		else if (tx_take) tx_cnt_r <= tx_last ? 3'h0 : tx_cnt_r + 3'h1;
	end
	rx_off_a: assert property (!ctl_enable |-> !rx_ready)
		else $error("byte accepted while disabled");
	busy_rx_a: assert property (tx_valid |-> !rx_ready)
		else $error("command taken during reply");
	reply_time_a: assert property (
		rx_take && rx_cnt_r == 4'h8 |-> ##[2:3] tx_valid)
		else $error("no reply after ninth byte");
	frame_gap_a: assert property (
		rx_take && rx_cnt_r == 4'h8 |=> !rx_ready [*2])
		else $error("byte taken before reply");
	tx_hold_a: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("reply byte dropped while stalled");
	echo_code_a: assert property (tx_valid && tx_cnt_r == 3'h0 |->
		tx_data == code_r || tx_data == GCI_BAD_CMD)
		else $error("reply code not echoed");
	bad_single_a: assert property (tx_valid && tx_cnt_r == 3'h0 &&
		tx_data == GCI_BAD_CMD |-> tx_last)
		else $error("bad code reply longer than one byte");
	last_early_a: assert property (tx_valid && tx_last |->
		tx_cnt_r == 3'h4 || (tx_cnt_r == 3'h0 && tx_data == GCI_BAD_CMD))
		else $error("reply ended early");
	last_at_five_a: assert property (tx_valid && tx_cnt_r == 3'h4 |-> tx_last)
		else $error("reply longer than five bytes");
endmodule : gci_top_checker
bind gci_top gci_top_checker gci_top_checker_i (.clk(clk), .nrst(nrst),
	.ctl_enable(ctl_enable), .rx_valid(rx_valid), .rx_data(rx_data),
	.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
	.tx_last(tx_last), .tx_ready(tx_ready));

//--- bench/gci_host_model.sv
// Host model: sends whole commands and gathers replies
`timescale 1ns/1ps
module gci_host_model (
	input wire logic clk,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready
);
	logic slow = 1'b0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// One frame, then its reply; stalls alternate cycles when slow
	task automatic xfer(input logic [71:0] f, output logic [47:0] r);
		int k;
		int c;
		logic done;
		logic [39:0] d;
		c = 0;
		d = 40'h0;
		done = 1'b0;
		r = 48'h0;
		for (int i = 0; i < 9; i++) begin
			rx_valid = 1'b1;
			rx_data = f[8*i+:8];
			for (k = 0; k < 20; k++) begin
				@(negedge clk);
				if (rx_ready === 1'b1) break;
			end
			@(posedge clk);
			#1;
			if (k == 20) begin
				rx_valid = 1'b0;
				return;
			end
		end
		rx_valid = 1'b0;
		rx_data = ~rx_data; // Released line must not look valid
		tx_ready = !slow;
		for (k = 0; k < 40 && !done; k++) begin
			@(negedge clk);
			if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
				if (c < 5) d[8*c+:8] = tx_data;
				c++;
				done = tx_last;
			end
			@(posedge clk);
			#1;
			if (!done) tx_ready = !slow || k[0];
		end
		tx_ready = 1'b0;
		r = {8'(c), d};
	endtask : xfer
endmodule : gci_host_model

//--- bench/test_gci_top.sv
// Self-checking testbench for the pin command interpreter
`timescale 1ns/1ps
module test_gci_top;
	import gci_pkg::*;
	typedef struct {
		logic [7:0] c;
		logic [31:0] m;
		logic [31:0] v;
		logic [39:0] e;
	} gci_row_s;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ctl_enable = 1'b1;
	logic boot_load = 1'b0;
	logic [2:0] boot_func = 3'h3;
	logic [2:0] boot_dir = 3'h0;
	logic [2:0] boot_level = 3'h0;
	logic [2:0] pin_in = 3'h2;
	logic rx_valid, rx_ready, tx_valid, tx_last, tx_ready;
	logic [7:0] rx_data, tx_data;
	logic [2:0] pin_out, pin_oe;
	logic [47:0] got;
	int fail_count = 0;
	int n_compared = 0;
	gci_row_s rows[8] = '{
		'{8'h10, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 40'h00_0000_0710},
		'{8'h12, 32'h0, 32'h0, 40'h00_0000_0712},
		'{8'h13, 32'h0, 32'h0, 40'h00_0000_0513},
		'{8'h19, 32'h0000_0003, 32'hFFFF_FFFD, 40'h00_0000_0119},
		'{8'h11, 32'h0, 32'h0, 40'h00_0000_0111},
		'{8'h1A, 32'h0000_0001, 32'h0, 40'h00_0000_061A},
		'{8'h1B, 32'hFFFF_FFFF, 32'h0000_0001, 40'h00_0000_051B},
		'{8'h55, 32'h0, 32'h0, 40'h00_0000_00FF}
	};
	always #25 clk = ~clk;
	gci_top #(.NPINS(3)) gci_top_i (.clk(clk), .nrst(nrst),
		.ctl_enable(ctl_enable), .boot_load(boot_load),
		.boot_func(boot_func), .boot_dir(boot_dir), .boot_level(boot_level),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe));
	gci_host_model gci_host_model_i (.clk(clk), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
	// Compare and count
	task automatic chk(input string what, input logic [47:0] e, g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	// Expected length follows from the reply code
	task automatic cmd(input logic [7:0] c, input logic [31:0] m, v,
		input logic [39:0] e);
		logic [47:0] r;
		gci_host_model_i.xfer({v, m, c}, r);
		chk("reply", {(e[7:0] === GCI_BAD_CMD) ? 8'h01 : 8'h05, e}, r);
	endtask : cmd
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up
	// Watchdog, several times the expected run
	initial begin
		#100us;
		fail_count++;
		wrap_up();
	end
	// Reset check first, then table, refusal, boot and mid-run reset cases
	initial begin
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		chk("reset outs", 48'({pin_oe, pin_out, tx_valid, rx_ready}), 48'h1);
		foreach (rows[i]) cmd(rows[i].c, rows[i].m, rows[i].v, rows[i].e);
		chk("pins", 48'({pin_oe, pin_out[0]}), 48'h3);
		$display("test table done");
		ctl_enable = 1'b0;
		gci_host_model_i.xfer({64'h0, 8'h10}, got);
		chk("refused", got, 48'h0);
		ctl_enable = 1'b1;
		cmd(8'h13, 32'h0, 32'h0, 40'h00_0000_0513);
		$display("test disable done");
		gci_host_model_i.slow = 1'b1;
		boot_load = 1'b1;
		@(posedge clk);
		#1 boot_load = 1'b0;
		cmd(8'h10, 32'h0, 32'h0, 40'h00_0000_0310);
		cmd(8'h19, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 40'h00_0000_0319);
		cmd(8'h13, 32'h0, 32'h0, 40'h00_0000_0013);
		cmd(8'h00, 32'h0, 32'h0, 40'h00_0000_00FF);
		$display("test boot done");
		nrst = 1'b0;
		@(posedge clk);
		#1 nrst = 1'b1;
		chk("reset again", 48'({pin_oe, pin_out, tx_valid, rx_ready}),
			48'h1);
		cmd(8'h11, 32'h0, 32'h0, 40'h00_0000_0011);
		cmd(8'h10, 32'h0, 32'h0, 40'h00_0000_0710);
		$display("test reset done");
		wrap_up();
	end
endmodule : test_gci_top
